// ===== hdl/ctr_map.svh
`ifndef CTR_MAP_SVH
`define CTR_MAP_SVH

// Register sub-addresses
`define CTR_ADDR_CELLS     8'h43
`define CTR_ADDR_ICODE     8'h44
`define CTR_ADDR_VCODE     8'h45
`define CTR_ADDR_LIMCODE   8'h46
`define CTR_ADDR_VBATFILT  8'h47
`define CTR_ADDR_ISAMPLE   8'h48
`define CTR_ADDR_VALID     8'h4a

// Field positions
`define CTR_CELLS_MSB      3
`define CTR_ICODE_MSB      4
`define CTR_VCODE_MSB      5
`define CTR_LIMCODE_MSB    5
`define CTR_VALID_BIT      0

// Reset values
`define CTR_RST_CODE5      5'h00
`define CTR_RST_CODE6      6'h00
`define CTR_RST_WORD       16'h0000

// Chemistry codes
`define CTR_CHEM_LI_LAST   4'h6
`define CTR_CHEM_PB_FIXED  4'h7
`define CTR_CHEM_PB_PROG   4'h8

// Timing
`define CTR_CLK_NS         4
`define CTR_RAMP_STEP_NS   10000
`define CTR_RAMP_STEP_CYC  ((`CTR_RAMP_STEP_NS + `CTR_CLK_NS - 1) / `CTR_CLK_NS)
`define CTR_FILT_SHIFT     3
`define CTR_WARMUP_SAMPLES 8

`endif

// ===== hdl/ctr_pkg.sv
package ctr_pkg;

  typedef enum logic [1:0] {
    LVL_LOW  = 2'h0,
    LVL_HIGH = 2'h1,
    LVL_OPEN = 2'h2
  } ctr_level_t;

  typedef struct packed {
    ctr_level_t pinC;
    ctr_level_t pinB;
    ctr_level_t pinA;
  } ctr_sel_pins_t;

  typedef enum logic [3:0] {
    RAMP_IDLE = 4'h1,
    RAMP_UP   = 4'h2,
    RAMP_HOLD = 4'h4,
    RAMP_DOWN = 4'h8
  } ctr_ramp_t;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [7:0]  addr;
    logic [15:0] wdata;
  } ctr_reg_req_t;

endpackage

// ===== hdl/ctr_telemetry_readback.sv
`timescale 1ns/100ps
`include "ctr_map.svh"
// Summary of operation
// - Cell count at 0x43 decoded from three three-level pins; invalid patterns flagged.
// - Field 0x44 shows the charge-current code actually applied to the converter.
// - Applied charge-current code steps up at start and down at stop.
// - Charge-current target comes from chemistry, state, thermistor ratio and settings.
// - Sense servo voltage equals applied current code plus one, in millivolts.
// - Field 0x45 shows applied charge-voltage code built from settings and offsets.
// - Field 0x46 shows input-limit code, following the programmed limit setting.
// - Register 0x47 holds filtered two's complement battery-voltage result.
// - Register 0x48 holds battery current sample used in latest resistance calculation.
// - Bit 0 at 0x4A reads one only when telemetry outputs are valid.
module ctr_telemetry_readback
  import ctr_pkg::*;
#(
  parameter int RAMP_STEP_CYC = `CTR_RAMP_STEP_CYC,
  parameter int FILT_SHIFT    = `CTR_FILT_SHIFT,
  parameter int WARMUP        = `CTR_WARMUP_SAMPLES
) (
  // Clock and reset
  input  wire logic          ref_clk,
  input  wire logic          rstn,
  // Configuration pins
  input  wire ctr_sel_pins_t cellSelPins,
  input  wire logic [3:0]    chemCode,
  // Charger state
  input  wire logic          chargeEnable,
  input  wire logic          absorbPhase,
  input  wire logic          equalizePhase,
  // Programmed settings
  input  wire logic [4:0]    programmedChargeCurrent,
  input  wire logic [4:0]    regionChargeCurrent,
  input  wire logic [5:0]    programmedChargeVoltage,
  input  wire logic [5:0]    regionChargeVoltage,
  input  wire logic [5:0]    absorbVoltageOffset,
  input  wire logic [5:0]    equalizeVoltageOffset,
  input  wire logic          regionEnable,
  input  wire logic [15:0]   regionThresholdHot,
  input  wire logic [15:0]   regionThresholdCold,
  input  wire logic          tempCompEnable,
  input  wire logic [5:0]    tempCompOffset,
  input  wire logic [5:0]    programmedInputLimit,
  // Measurements
  input  wire logic          measEnable,
  input  wire logic          measStrobe,
  input  wire logic [15:0]   thermistorRatio,
  input  wire logic [15:0]   batteryVoltageSample,
  input  wire logic [15:0]   batteryCurrentSample,
  input  wire logic          resistanceCalcDone,
  // Serial port register access
  input  wire ctr_reg_req_t  regReq,
  output logic [15:0]        regRdata,
  output logic               regRvalid,
  // Reference converter codes and cell-count error flag
  output logic [4:0]         appliedChargeCurrentCode,
  output logic [5:0]         senseServoMv,
  output logic [5:0]         appliedChargeVoltageCode,
  output logic [5:0]         appliedInputLimitCode,
  output logic               cellCountError
);

  localparam int CNT_W = $clog2(RAMP_STEP_CYC + 1);
  localparam int WU_W  = $clog2(WARMUP + 1);

  // Three-level pin pattern to cell count; bit 4 marks an invalid pattern
  function automatic logic [4:0] decodeCells(ctr_sel_pins_t p, logic leadAcid);
    logic [4:0] r;
    r = 5'h10;
    unique case ({p.pinC, p.pinB, p.pinA})
      {LVL_LOW,  LVL_LOW,  LVL_HIGH}: r = 5'h01;
      {LVL_LOW,  LVL_HIGH, LVL_LOW }: r = 5'h02;
      {LVL_LOW,  LVL_HIGH, LVL_HIGH}: r = 5'h03;
      {LVL_LOW,  LVL_LOW,  LVL_OPEN}: r = 5'h04;
      {LVL_LOW,  LVL_OPEN, LVL_LOW }: r = 5'h05;
      {LVL_LOW,  LVL_HIGH, LVL_OPEN}: r = 5'h06;
      {LVL_LOW,  LVL_OPEN, LVL_HIGH}: r = 5'h07;
      {LVL_LOW,  LVL_OPEN, LVL_OPEN}: r = 5'h08;
      {LVL_HIGH, LVL_LOW,  LVL_LOW }: r = 5'h09;
      {LVL_HIGH, LVL_HIGH, LVL_HIGH}: r = leadAcid ? 5'h0c : 5'h10;
      default:                        r = 5'h10;
    endcase
    return r;
  endfunction

  // Registers
  logic [3:0]         cells_r,     cells_nxt;
  logic               cellErr_r,   cellErr_nxt;
  logic [4:0]         iCode_r,     iCode_nxt;
  logic [5:0]         servo_r,     servo_nxt;
  logic [5:0]         vCode_r,     vCode_nxt;
  logic [5:0]         limCode_r,   limCode_nxt;
  logic [15:0]        vFilt_r,     vFilt_nxt;
  logic [15:0]        iSample_r,   iSample_nxt;
  logic               valid_r,     valid_nxt;
  logic [WU_W-1:0]    warm_r,      warm_nxt;
  logic [CNT_W-1:0]   div_r,       div_nxt;
  ctr_ramp_t          ramp_r,      ramp_nxt;
  logic [15:0]        rdata_r,     rdata_nxt;
  logic               rvalid_r,    rvalid_nxt;

  logic               leadAcid;
  logic               outOfRegion;
  logic               stepTick;
  logic [4:0]         iTarget;
  logic signed [16:0] filtDiff;

  assign leadAcid = (chemCode == `CTR_CHEM_PB_FIXED) || (chemCode == `CTR_CHEM_PB_PROG);
  // Lower ratio means hotter thermistor
  assign outOfRegion = regionEnable && !leadAcid &&
                       ((thermistorRatio < regionThresholdHot) ||
                        (thermistorRatio > regionThresholdCold));
  assign stepTick = (div_r == CNT_W'(RAMP_STEP_CYC - 1));
  assign filtDiff = $signed({batteryVoltageSample[15], batteryVoltageSample}) -
                    $signed({vFilt_r[15], vFilt_r});

  // Target current from chemistry, state and thermistor region
  always_comb begin
    iTarget = 5'h00;
    if (chargeEnable && !cellErr_r) begin
      iTarget = programmedChargeCurrent;
      if (outOfRegion && (regionChargeCurrent < programmedChargeCurrent)) begin
        iTarget = regionChargeCurrent;
      end
    end
  end

  // Cell decode and soft ramp
  always_comb begin
    logic [4:0] dec;
    dec       = decodeCells(cellSelPins, leadAcid);
    cells_nxt   = dec[3:0];
    cellErr_nxt = dec[4];
    div_nxt     = stepTick ? '0 : div_r + CNT_W'(1);
    iCode_nxt   = iCode_r;
    ramp_nxt    = ramp_r;
    unique case (ramp_r)
      RAMP_IDLE: begin
        if (iTarget != iCode_r) begin
          ramp_nxt = (iTarget > iCode_r) ? RAMP_UP : RAMP_DOWN;
        end
      end
      RAMP_UP: begin
        if (iTarget < iCode_r) begin
          ramp_nxt = RAMP_DOWN;
        end else if (iTarget == iCode_r) begin
          ramp_nxt = RAMP_HOLD;
        end else if (stepTick) begin
          iCode_nxt = iCode_r + 5'h01;
        end
      end
      RAMP_HOLD: begin
        if (iTarget > iCode_r) begin
          ramp_nxt = RAMP_UP;
        end else if (iTarget < iCode_r) begin
          ramp_nxt = RAMP_DOWN;
        end
      end
      RAMP_DOWN: begin
        if (iTarget > iCode_r) begin
          ramp_nxt = RAMP_UP;
        end else if (iTarget == iCode_r) begin
          ramp_nxt = (iCode_r == 5'h00) ? RAMP_IDLE : RAMP_HOLD;
        end else if (stepTick) begin
          iCode_nxt = iCode_r - 5'h01;
        end
      end
    endcase
    servo_nxt = {1'b0, iCode_nxt} + 6'h01;
  end

  // Voltage and input-limit codes
  always_comb begin
    logic signed [8:0] sum;
    sum = $signed({3'b000, programmedChargeVoltage});
    if (absorbPhase) begin
      sum = sum + $signed({3'b000, absorbVoltageOffset});
    end
    if (equalizePhase && leadAcid) begin
      sum = sum + $signed({3'b000, equalizeVoltageOffset});
    end
    if (tempCompEnable && leadAcid) begin
      sum = sum + $signed({{3{tempCompOffset[5]}}, tempCompOffset});
    end
    if (outOfRegion) begin
      sum = $signed({3'b000, regionChargeVoltage});
    end
    if (sum < 0) begin
      vCode_nxt = 6'h00;
    end else if (sum > 9'sd63) begin
      vCode_nxt = 6'h3f;
    end else begin
      vCode_nxt = sum[5:0];
    end
    limCode_nxt = programmedInputLimit;
  end

  // Measurement filter, resistance sample and valid flag
  always_comb begin
    logic signed [16:0] step;
    step        = filtDiff >>> FILT_SHIFT;
    vFilt_nxt   = vFilt_r;
    iSample_nxt = iSample_r;
    warm_nxt    = warm_r;
    if (!measEnable) begin
      warm_nxt = '0;
    end else if (measStrobe) begin
      if (warm_r == '0) begin
        vFilt_nxt = batteryVoltageSample;
      end else begin
        vFilt_nxt = vFilt_r + step[15:0];
      end
      if (warm_r != WU_W'(WARMUP)) begin
        warm_nxt = warm_r + WU_W'(1);
      end
    end
    if (resistanceCalcDone) begin
      iSample_nxt = batteryCurrentSample;
    end
    valid_nxt = measEnable && (warm_nxt == WU_W'(WARMUP));
  end

  // Read port; writes never reach any register
  always_comb begin
    rdata_nxt  = rdata_r;
    rvalid_nxt = regReq.rd;
    if (regReq.rd) begin
      unique case (regReq.addr)
        `CTR_ADDR_CELLS:    rdata_nxt = {12'h000, cells_r};
        `CTR_ADDR_ICODE:    rdata_nxt = {11'h000, iCode_r};
        `CTR_ADDR_VCODE:    rdata_nxt = {10'h000, vCode_r};
        `CTR_ADDR_LIMCODE:  rdata_nxt = {10'h000, limCode_r};
        `CTR_ADDR_VBATFILT: rdata_nxt = vFilt_r;
        `CTR_ADDR_ISAMPLE:  rdata_nxt = iSample_r;
        `CTR_ADDR_VALID:    rdata_nxt = {15'h0000, valid_r};
        default:            rdata_nxt = `CTR_RST_WORD;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cells_r   <= 4'h0;
      cellErr_r <= 1'b0;
      iCode_r   <= `CTR_RST_CODE5;
      servo_r   <= 6'h01;
      div_r     <= '0;
      ramp_r    <= RAMP_IDLE;
    end else begin
      cells_r   <= cells_nxt;
      cellErr_r <= cellErr_nxt;
      iCode_r   <= iCode_nxt;
      servo_r   <= servo_nxt;
      div_r     <= div_nxt;
      ramp_r    <= ramp_nxt;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      vCode_r   <= `CTR_RST_CODE6;
      limCode_r <= `CTR_RST_CODE6;
    end else begin
      vCode_r   <= vCode_nxt;
      limCode_r <= limCode_nxt;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      vFilt_r   <= `CTR_RST_WORD;
      iSample_r <= `CTR_RST_WORD;
      valid_r   <= 1'b0;
      warm_r    <= '0;
    end else begin
      vFilt_r   <= vFilt_nxt;
      iSample_r <= iSample_nxt;
      valid_r   <= valid_nxt;
      warm_r    <= warm_nxt;
    end
  end

  // Answer lands one cycle after the read request
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rdata_r   <= `CTR_RST_WORD;
      rvalid_r  <= 1'b0;
    end else begin
      rdata_r   <= rdata_nxt;
      rvalid_r  <= rvalid_nxt;
    end
  end

  assign regRdata                 = rdata_r;
  assign regRvalid                = rvalid_r;
  assign appliedChargeCurrentCode = iCode_r;
  assign senseServoMv             = servo_r;
  assign appliedChargeVoltageCode = vCode_r;
  assign appliedInputLimitCode    = limCode_r;
  assign cellCountError           = cellErr_r;

endmodule // ctr_telemetry_readback

// ===== tb/ctr_checker.sv
`timescale 1ns/100ps
`include "ctr_map.svh"
module ctr_checker
  import ctr_pkg::*;
#(
  parameter int RAMP_STEP_CYC = 4
) (
  // Clock and reset
  input wire logic         ref_clk,
  input wire logic         rstn,
  // Watched inputs
  input wire ctr_reg_req_t regReq,
  input wire logic [5:0]   programmedInputLimit,
  // Watched outputs
  input wire logic [15:0]  regRdata,
  input wire logic         regRvalid,
  input wire logic [4:0]   appliedChargeCurrentCode,
  input wire logic [5:0]   senseServoMv,
  input wire logic [5:0]   appliedChargeVoltageCode,
  input wire logic [5:0]   appliedInputLimitCode,
  input wire logic         cellCountError
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  logic [4:0] codePrev_r;
  int         stepAge_r;
  int         stepAge_nxt;
  // Cycles since the applied current code last moved
  always_comb begin
    stepAge_nxt = (stepAge_r < 1000) ? stepAge_r + 1 : stepAge_r;
    if (appliedChargeCurrentCode != codePrev_r) begin
      stepAge_nxt = 0;
    end
  end
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      codePrev_r <= 5'h00;
      stepAge_r  <= 1000;
    end else begin
      codePrev_r <= appliedChargeCurrentCode;
      stepAge_r  <= stepAge_nxt;
    end
  end
  sequence s_read(logic [7:0] a);
    regReq.rd && regReq.addr == a;
  endsequence
  property p_field(logic [7:0] a, logic [15:0] v);
    s_read(a) |=> regRdata == $past(v);
  endproperty
  a_read_answer: assert property (regReq.rd |=> regRvalid)
    else $error("read not answered next cycle");
  a_no_stray_valid: assert property (regRvalid |-> $past(regReq.rd))
    else $error("read data valid without a read");
  a_write_ignored: assert property (regReq.wr && !regReq.rd |=> !regRvalid)
    else $error("write produced an answer");
  a_count_error: assert property (s_read(8'h43) ##0 cellCountError |=> regRdata == 16'h0000)
    else $error("invalid select pattern read nonzero");
  a_current_field: assert property (p_field(`CTR_ADDR_ICODE, {11'h0, appliedChargeCurrentCode}))
    else $error("current field differs from applied code");
  a_voltage_field: assert property (p_field(`CTR_ADDR_VCODE, {10'h0, appliedChargeVoltageCode}))
    else $error("voltage field differs from applied code");
  a_limit_field: assert property (p_field(`CTR_ADDR_LIMCODE, {10'h0, appliedInputLimitCode}))
    else $error("limit field differs from applied code");
  a_servo_offset: assert property (senseServoMv == {1'b0, appliedChargeCurrentCode} + 6'h01)
    else $error("servo level not code plus one");
  a_ramp_unit: assert property ($changed(appliedChargeCurrentCode) |->
    (appliedChargeCurrentCode - $past(appliedChargeCurrentCode)) inside {5'h01, 5'h1f})
    else $error("current code jumped by more than one");
  a_ramp_spacing: assert property ($changed(appliedChargeCurrentCode) |->
    stepAge_r >= RAMP_STEP_CYC - 1) else $error("current code stepped too soon");
  a_limit_follow: assert property ($past(rstn, 2) |->
    appliedInputLimitCode == $past(programmedInputLimit)) else $error("limit code lags setting");
endmodule // ctr_checker

// ===== tb/ctr_host.sv
`timescale 1ns/100ps
module ctr_host
  import ctr_pkg::*;
(
  // Clock
  input wire logic    ref_clk,
  // Register request
  output ctr_reg_req_t regReq
);
  initial regReq = '0;
  // One-cycle request; idle address and data are inverted so stale values never match
  task automatic access(input logic wr, input logic [7:0] a, input logic [15:0] wd);
    @(negedge ref_clk);
    regReq = '{rd: !wr, wr: wr, addr: a, wdata: wd};
    @(negedge ref_clk);
    regReq = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~wd};
  endtask
endmodule // ctr_host

// ===== tb/tb_ctr_telemetry_readback.sv
`timescale 1ns/100ps
`include "ctr_map.svh"
module tb_ctr_telemetry_readback
  import ctr_pkg::*;
;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  ctr_reg_req_t regReq;
  ctr_sel_pins_t cellSelPins;
  logic [3:0] chemCode;
  logic chargeEnable, absorbPhase, equalizePhase, regionEnable, tempCompEnable;
  logic measEnable, measStrobe, resistanceCalcDone, regRvalid, cellCountError;
  logic [4:0] programmedChargeCurrent, regionChargeCurrent, appliedChargeCurrentCode;
  logic [5:0] programmedChargeVoltage, regionChargeVoltage, absorbVoltageOffset;
  logic [5:0] equalizeVoltageOffset, tempCompOffset, programmedInputLimit;
  logic [5:0] senseServoMv, appliedChargeVoltageCode, appliedInputLimitCode;
  logic [15:0] regionThresholdHot, regionThresholdCold, thermistorRatio, regRdata;
  logic [15:0] batteryVoltageSample, batteryCurrentSample, s1, s2, v;
  logic [16:0] d;
  logic signed [8:0] sum;
  logic [15:0] expQ [$];
  logic [31:0] lfsr = 32'h46300d59;
  logic [5:0] pinTab [14] = '{6'h00, 6'h01, 6'h04, 6'h05, 6'h02, 6'h08, 6'h06,
                              6'h09, 6'h0a, 6'h10, 6'h11, 6'h14, 6'h15, 6'h20};
  logic [15:0] cntTab [14] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 9, 0, 0, 12, 0};
  logic [3:0] chems [2] = '{4'h1, 4'h8};
  int errCount = 0;
  int checks = 0;
  int cyc = 0;

  ctr_telemetry_readback #(.RAMP_STEP_CYC(4), .WARMUP(2)) ctr_telemetry_readback_i (
    .ref_clk, .rstn, .cellSelPins, .chemCode, .chargeEnable, .absorbPhase, .equalizePhase,
    .programmedChargeCurrent, .regionChargeCurrent, .programmedChargeVoltage,
    .regionChargeVoltage, .absorbVoltageOffset, .equalizeVoltageOffset, .regionEnable,
    .regionThresholdHot, .regionThresholdCold, .tempCompEnable, .tempCompOffset,
    .programmedInputLimit, .measEnable, .measStrobe, .thermistorRatio,
    .batteryVoltageSample, .batteryCurrentSample, .resistanceCalcDone, .regReq, .regRdata,
    .regRvalid, .appliedChargeCurrentCode, .senseServoMv, .appliedChargeVoltageCode,
    .appliedInputLimitCode, .cellCountError);
  ctr_host ctr_host_i (.ref_clk, .regReq);

  initial begin
    forever #2 ref_clk = ~ref_clk;
  end

  function automatic logic [31:0] nextRand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic compare(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      errCount++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    expQ.push_back(exp);
    ctr_host_i.access(1'b0, a, 16'h0000);
  endtask

  task automatic settle;
    repeat (2) @(negedge ref_clk);
  endtask

  task automatic strobe(input logic [15:0] s);
    @(negedge ref_clk);
    batteryVoltageSample = s;
    measStrobe = 1'b1;
    @(negedge ref_clk);
    measStrobe = 1'b0;
    batteryVoltageSample = ~s;
  endtask

  task automatic test_done;
    if (expQ.size() != 0) errCount++;
    $display("checks=%0d errors=%0d", checks, errCount);
    if (errCount == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // Answers are matched in order against the oldest expectation
  always @(negedge ref_clk) begin
    if (regRvalid === 1'b1) begin
      if (expQ.size() == 0) compare(regRdata, ~regRdata);
      else compare(regRdata, expQ.pop_front());
    end
  end

  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 5000) begin
      errCount++;
      test_done;
    end
  end

  initial begin
    {chargeEnable, absorbPhase, equalizePhase, regionEnable, tempCompEnable, measEnable,
     measStrobe, resistanceCalcDone, programmedChargeCurrent, regionChargeCurrent,
     programmedChargeVoltage, regionChargeVoltage, absorbVoltageOffset, tempCompOffset,
     equalizeVoltageOffset, programmedInputLimit, regionThresholdHot, thermistorRatio,
     batteryVoltageSample, batteryCurrentSample, chemCode, cellSelPins} = '0;
    regionThresholdCold = 16'hffff;
    repeat (6) @(negedge ref_clk);
    rstn = 1'b1;
    foreach (chems[k]) for (int i = 0; i < 14; i++) begin
      chemCode = chems[k];
      cellSelPins = pinTab[i];
      settle;
      v = (i == 12 && chems[k] != 4'h8) ? 16'h0 : cntTab[i];
      compare({15'h0, cellCountError}, {15'h0, v == 16'h0});
      rd(`CTR_ADDR_CELLS, v);
    end
    cellSelPins = 6'h01;
    // Equalize and temperature compensation only move a lead-acid target
    for (int i = 0; i < 4; i++) begin
      lfsr = nextRand(lfsr);
      chemCode = chems[i % 2];
      {equalizePhase, tempCompEnable, tempCompOffset, programmedInputLimit, absorbPhase,
       absorbVoltageOffset, programmedChargeVoltage} = lfsr[26:0];
      equalizeVoltageOffset = lfsr[31:26];
      settle;
      sum = programmedChargeVoltage + (absorbPhase ? absorbVoltageOffset : 6'h00);
      if (chemCode == 4'h8) begin
        sum = sum + (equalizePhase ? equalizeVoltageOffset : 6'h00) +
              (tempCompEnable ? {{3{tempCompOffset[5]}}, tempCompOffset} : 9'h000);
      end
      rd(`CTR_ADDR_VCODE, (sum < 0) ? 16'h0000 : (sum > 63) ? 16'h003f : {7'h0, sum});
      rd(`CTR_ADDR_LIMCODE, {10'h0, programmedInputLimit});
    end
    chemCode = 4'h1;
    programmedChargeCurrent = lfsr[4:0] | 5'h10;
    chargeEnable = 1'b1;
    repeat (200) @(negedge ref_clk);
    rd(`CTR_ADDR_ICODE, {11'h0, programmedChargeCurrent});
    ctr_host_i.access(1'b1, `CTR_ADDR_ICODE, ~lfsr[15:0]);
    ctr_host_i.access(1'b1, `CTR_ADDR_VALID, 16'hffff);
    rd(`CTR_ADDR_ICODE, {11'h0, programmedChargeCurrent});
    rd(`CTR_ADDR_VALID, 16'h0000);
    rd(8'h49, 16'h0000);
    regionEnable = 1'b1;
    regionThresholdHot = 16'h4000;
    thermistorRatio = 16'h1000;
    regionChargeCurrent = 5'h03;
    regionChargeVoltage = lfsr[21:16];
    repeat (200) @(negedge ref_clk);
    rd(`CTR_ADDR_ICODE, 16'h0003);
    rd(`CTR_ADDR_VCODE, {10'h0, regionChargeVoltage});
    chargeEnable = 1'b0;
    repeat (200) @(negedge ref_clk);
    rd(`CTR_ADDR_ICODE, 16'h0000);
    measEnable = 1'b1;
    s1 = {{3{lfsr[12]}}, lfsr[12:0]};
    s2 = {{3{lfsr[31]}}, lfsr[31:19]};
    strobe(s1);
    settle;
    rd(`CTR_ADDR_VBATFILT, s1);
    rd(`CTR_ADDR_VALID, 16'h0000);
    strobe(s2);
    settle;
    d = {s2[15], s2} - {s1[15], s1};
    v = s1 + 16'($signed(d) >>> 3);
    rd(`CTR_ADDR_VBATFILT, v);
    rd(`CTR_ADDR_VALID, 16'h0001);
    measEnable = 1'b0;
    settle;
    rd(`CTR_ADDR_VALID, 16'h0000);
    batteryCurrentSample = lfsr[15:0];
    resistanceCalcDone = 1'b1;
    @(negedge ref_clk);
    resistanceCalcDone = 1'b0;
    batteryCurrentSample = ~lfsr[15:0];
    settle;
    rd(`CTR_ADDR_ISAMPLE, lfsr[15:0]);
    repeat (3) @(negedge ref_clk);
    test_done;
  end
endmodule // tb_ctr_telemetry_readback

bind ctr_telemetry_readback ctr_checker #(.RAMP_STEP_CYC(RAMP_STEP_CYC)) ctr_checker_i (
  .ref_clk, .rstn, .regReq, .programmedInputLimit, .regRdata, .regRvalid,
  .appliedChargeCurrentCode, .senseServoMv, .appliedChargeVoltageCode,
  .appliedInputLimitCode, .cellCountError);
